// ### ivpr_top.sv
// Interrupt priority resolver, vector supply and reset gathering logic.
// Assumes peripherals pulse requests on clk_sys_in; reset pin and the
// power and voltage detectors are asynchronous and are synchronised here.
`timescale 1ns/100ps
`default_nettype none
module ivpr_top (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Maskable request events from peripherals.
  input wire logic timer_ch10_done_irq_in,
  input wire logic timer_ch11_done_irq_in,
  input wire logic timer_ch12_done_irq_in,
  input wire logic timer_ch13_done_irq_in,
  input wire logic muldiv_done_irq_in,
  // Interrupt handshake with the core.
  input wire logic irq_ack_in,
  output logic irq_req_out,
  output logic [19:0] irq_vector_out,
  output logic [5:0] irq_prio_out,
  // Instruction execution from the core.
  input wire logic instr_exec_in,
  input wire logic [7:0] instr_opcode_in,
  input wire logic software_break_instr_in,
  input wire logic debug_emulation_in,
  output logic break_req_out,
  output logic [19:0] break_vector_out,
  // Reset sources.
  input wire logic reset_pin_n_in,
  input wire logic power_on_clear_in,
  input wire logic low_voltage_detect_in,
  input wire logic [7:0] low_voltage_ctrl_reg_in,
  input wire logic watchdog_overflow_reset_in,
  // Halt state and reset outcome.
  input wire logic halt_active_in,
  output logic halt_release_out,
  output logic core_reset_out,
  output logic pc_load_out,
  output logic [19:0] pc_vector_out,
  output logic [4:0] reset_cause_out
);
  localparam int N = ivpr_pkg::NUM_SRC;

  logic [N-1:0] evt;
  logic [N-1:0] pend;
  logic [N-1:0] grant_onehot;
  logic [N-1:0] ack_vec;
  logic pin_low_sync;
  logic pwr_clear_sync;
  logic lvd_sync;
  logic low_voltage_reset_select;
  logic trap_hit;
  logic lvd_reset;
  logic any_reset;
  logic [4:0] cause_now;
  logic [2:0] hold_reg;
  logic [2:0] hold_next;
  logic in_reset_reg;
  logic pc_load_reg;
  logic [4:0] cause_reg;
  logic [4:0] cause_next;
  logic halt_rel_reg;
  logic break_pulse_reg;
  logic [19:0] vec_reg;
  logic [19:0] vec_next;
  logic [5:0] prio_reg;
  logic [5:0] prio_next;
  logic req_reg;

  // Event bits ordered from highest to lowest default priority.
  assign evt = {muldiv_done_irq_in, timer_ch13_done_irq_in, timer_ch12_done_irq_in,
                timer_ch11_done_irq_in, timer_ch10_done_irq_in};

  // One sticky pending flag per maskable source.
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_pend
      ivpr_pending u_pend (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .event_in(evt[g]),
        .ack_in(ack_vec[g]),
        .pend_out(pend[g])
      );
    end
  endgenerate

  // Lowest index wins, which is the highest default priority.
  assign grant_onehot = pend & (~pend + {{(N-1){1'b0}}, 1'b1});
  assign ack_vec = grant_onehot & {N{irq_ack_in & req_reg}};

  // Vector and priority of the winning source.
  assign vec_next = grant_onehot[0] ? ivpr_pkg::VEC_TM10 :
                    grant_onehot[1] ? ivpr_pkg::VEC_TM11 :
                    grant_onehot[2] ? ivpr_pkg::VEC_TM12 :
                    grant_onehot[3] ? ivpr_pkg::VEC_TM13 :
                    ivpr_pkg::VEC_MULDIV;
  assign prio_next = grant_onehot[0] ? ivpr_pkg::PRIO_TM10 :
                     grant_onehot[1] ? ivpr_pkg::PRIO_TM11 :
                     grant_onehot[2] ? ivpr_pkg::PRIO_TM12 :
                     grant_onehot[3] ? ivpr_pkg::PRIO_TM13 :
                     ivpr_pkg::PRIO_MULDIV;

  // Asynchronous reset sources pass two flip-flops first.
  ivpr_sync2 u_sync_pin (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .async_in(~reset_pin_n_in),
    .sync_out(pin_low_sync)
  );
  ivpr_sync2 u_sync_pwr (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .async_in(power_on_clear_in),
    .sync_out(pwr_clear_sync)
  );
  ivpr_sync2 u_sync_lvd (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .async_in(low_voltage_detect_in),
    .sync_out(lvd_sync)
  );

  // Reset source qualification.
  assign low_voltage_reset_select = low_voltage_ctrl_reg_in[ivpr_pkg::LV_RESET_SEL_BIT];
  assign lvd_reset = lvd_sync & low_voltage_reset_select;
  assign trap_hit = instr_exec_in & (instr_opcode_in == ivpr_pkg::ILLEGAL_OPCODE)
                    & ~debug_emulation_in;
  assign cause_now = {trap_hit, watchdog_overflow_reset_in, lvd_reset, pwr_clear_sync,
                      pin_low_sync};
  assign any_reset = |cause_now;
  assign cause_next = any_reset ? cause_now : cause_reg;
  assign hold_next = any_reset ? ivpr_pkg::RESET_HOLD_CYCLES :
                     (hold_reg != 3'h0) ? hold_reg - 3'h1 : 3'h0;

  // Reset sequencing: hold core in reset, then load the reset vector.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      hold_reg <= ivpr_pkg::RESET_HOLD_CYCLES;
      in_reset_reg <= 1'b1;
      pc_load_reg <= 1'b0;
      cause_reg <= 5'h00;
      halt_rel_reg <= 1'b0;
    end else begin
      hold_reg <= hold_next;
      in_reset_reg <= any_reset | (hold_reg != 3'h0);
      pc_load_reg <= ~any_reset & (hold_reg == 3'h1);
      cause_reg <= cause_next;
      halt_rel_reg <= any_reset & halt_active_in;
    end
  end

  // Maskable request and software break outputs.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || in_reset_reg) begin
      req_reg <= 1'b0;
      vec_reg <= ivpr_pkg::VEC_RESET;
      prio_reg <= 6'h00;
      break_pulse_reg <= 1'b0;
    end else begin
      req_reg <= (|pend) & ~(irq_ack_in & req_reg) | (|(pend & ~ack_vec));
      vec_reg <= vec_next;
      prio_reg <= prio_next;
      break_pulse_reg <= instr_exec_in & software_break_instr_in;
    end
  end

  assign irq_req_out = req_reg;
  assign irq_vector_out = vec_reg;
  assign irq_prio_out = prio_reg;
  assign break_req_out = break_pulse_reg;
  assign break_vector_out = ivpr_pkg::VEC_BREAK;
  assign core_reset_out = in_reset_reg;
  assign pc_load_out = pc_load_reg;
  assign pc_vector_out = ivpr_pkg::VEC_RESET;
  assign reset_cause_out = cause_reg;
  assign halt_release_out = halt_rel_reg;

  // Checks. Each one guards a single rule and sits beside the logic above it.

  // A reset source, then four quiet cycles while the core is held in reset.
  sequence s_reset_then_quiet;
    any_reset ##1 !any_reset [*4];
  endsequence

  // The core takes channel 10 while no new channel 10 event lands.
  sequence s_take_tm10;
    irq_req_out && irq_ack_in && grant_onehot[0] && !timer_ch10_done_irq_in;
  endsequence

  // Low-voltage detection seen while the reset select bit is set.
  sequence s_lvd_selected;
    lvd_sync && low_voltage_reset_select;
  endsequence

  // Channel 10 pending must always set the presented priority.
  a_prio_order: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (pend[0] && !in_reset_reg && !$past(in_reset_reg)) |=> (prio_reg == ivpr_pkg::PRIO_TM10)
    || $past(in_reset_reg))
    else $error("Highest pending request not selected.");

  // A presented request stands until the core takes it.
  a_req_stands: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (irq_req_out && !irq_ack_in && !core_reset_out) |=> irq_req_out)
    else $error("Request dropped before it was taken.");

  // The presented priority lies in the ranked range of the five sources.
  a_prio_range: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    irq_req_out |-> (irq_prio_out >= ivpr_pkg::PRIO_TM10)
    && (irq_prio_out <= ivpr_pkg::PRIO_MULDIV))
    else $error("Priority outside the ranked range.");

  // Channel 11 winning must present its own vector.
  a_tm11_vec: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (grant_onehot[1] && !in_reset_reg) |=> (vec_reg == ivpr_pkg::VEC_TM11) || in_reset_reg)
    else $error("Wrong vector for channel 11.");

  // A presented vector always names one of the five maskable sources.
  a_vec_known: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    irq_req_out |-> (irq_vector_out == ivpr_pkg::VEC_TM10) || (irq_vector_out == ivpr_pkg::VEC_TM11)
    || (irq_vector_out == ivpr_pkg::VEC_TM12) || (irq_vector_out == ivpr_pkg::VEC_TM13)
    || (irq_vector_out == ivpr_pkg::VEC_MULDIV))
    else $error("Unknown vector presented.");

  // Multiply/divide alone must present its own vector.
  a_muldiv_vec: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (pend == 5'h10 && !in_reset_reg) |=> (vec_reg == ivpr_pkg::VEC_MULDIV) || in_reset_reg)
    else $error("Wrong vector for multiply/divide.");

  // A channel 10 event is never lost.
  a_tm10_pend: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    timer_ch10_done_irq_in |=> pend[0])
    else $error("Channel 10 event lost.");

  // Taking channel 10 clears its flag when no new event lands with it.
  a_tm10_taken: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    s_take_tm10 |=> !pend[0])
    else $error("Channel 10 still pending after it was taken.");

  // An executed break raises the break request.
  a_break_req: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (instr_exec_in && software_break_instr_in && !in_reset_reg) |=> break_req_out)
    else $error("Break not raised.");

  // A break request only ever follows an executed break.
  a_break_pulse: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    break_req_out |-> $past(instr_exec_in) && $past(software_break_instr_in))
    else $error("Break raised without a break instruction.");

  // Watchdog overflow resets the core and records its cause.
  a_wdt_reset: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    watchdog_overflow_reset_in |=> core_reset_out && reset_cause_out[3])
    else $error("Watchdog overflow did not reset.");

  // An executed illegal opcode resets the core.
  a_trap_reset: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (instr_exec_in && instr_opcode_in == ivpr_pkg::ILLEGAL_OPCODE && !debug_emulation_in)
    |=> core_reset_out)
    else $error("Illegal opcode did not reset.");

  // No trap is raised while the emulator is attached.
  a_trap_debug: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (trap_hit) |-> !debug_emulation_in)
    else $error("Trap raised under emulation.");

  // Low-voltage detection is ignored while not selected as a reset.
  a_lvd_gate: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (lvd_sync && !low_voltage_ctrl_reg_in[1]) |-> !lvd_reset)
    else $error("Low voltage reset while not selected.");

  // Selected low-voltage detection resets the core and records its cause.
  a_lvd_reset: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    s_lvd_selected |=> core_reset_out && reset_cause_out[2])
    else $error("Selected low voltage did not reset.");

  // A reset while halted releases the halt.
  a_halt_exit: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (any_reset && halt_active_in) |=> halt_release_out)
    else $error("Halt not released by reset.");

  // Halt release follows only a reset seen while halted.
  a_halt_quiet: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !(any_reset && halt_active_in) |=> !halt_release_out)
    else $error("Halt released without a reset.");

  // The reset vector is loaded once the hold time has run out.
  a_reset_vec: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    s_reset_then_quiet |=> pc_load_out)
    else $error("Reset vector not loaded after reset.");

  // The reset vector load is a single-cycle pulse.
  a_pc_load_pulse: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    pc_load_out |=> !pc_load_out)
    else $error("Reset vector load longer than one cycle.");

  // A low level on the reset pin resets the core.
  a_pin_reset: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    pin_low_sync |=> core_reset_out && reset_cause_out[0])
    else $error("Reset pin did not reset.");

  // Power-on-clear resets the core.
  a_pwr_reset: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    pwr_clear_sync |=> core_reset_out && reset_cause_out[1])
    else $error("Power-on-clear did not reset.");

  // Outputs of the request path stay idle while the core is held in reset.
  a_reset_idle: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    core_reset_out |=> !irq_req_out && !break_req_out)
    else $error("Request raised while core held in reset.");

  // Latched causes change only when a new reset arrives.
  a_cause_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !any_reset |=> $stable(reset_cause_out))
    else $error("Reset cause changed without a reset.");
endmodule : ivpr_top
`default_nettype wire

// ### ivpr_pkg.sv
// Constants shared by the interrupt vector, priority and reset block.
// Assumes a single system clock domain; no software-visible registers.
// Summary of operation
// - Simultaneous maskable requests are granted by fixed priority, 0 highest, 45 lowest.
// - Timer channel 10 event raises request at priority 41, vector 00056H.
// - Timer channels 11, 12, 13 raise requests at vectors 00058H, 0005AH, 0005CH.
// - Multiply/divide completion raises lowest priority 45 request, vector 0005EH.
// - Software break is non-maskable, unranked, vectored at 0007EH.
// - Watchdog overflow is a reset source, restarting through the reset vector.
// - Executing opcode FFH is an illegal instruction and causes a trap reset.
// - The illegal-instruction trap reset is suppressed under a debug emulator.
// - Low-voltage detection resets only when reset-select bit 1 is set.
// - A reset during halt ends halt, then runs a normal reset sequence.
package ivpr_pkg;
  localparam int NUM_SRC = 5;
  localparam logic [19:0] VEC_TM10 = 20'h00056;
  localparam logic [19:0] VEC_TM11 = 20'h00058;
  localparam logic [19:0] VEC_TM12 = 20'h0005a;
  localparam logic [19:0] VEC_TM13 = 20'h0005c;
  localparam logic [19:0] VEC_MULDIV = 20'h0005e;
  localparam logic [19:0] VEC_BREAK = 20'h0007e;
  localparam logic [19:0] VEC_RESET = 20'h00000;
  localparam logic [5:0] PRIO_TM10 = 6'h29;
  localparam logic [5:0] PRIO_TM11 = 6'h2a;
  localparam logic [5:0] PRIO_TM12 = 6'h2b;
  localparam logic [5:0] PRIO_TM13 = 6'h2c;
  localparam logic [5:0] PRIO_MULDIV = 6'h2d;
  localparam logic [7:0] ILLEGAL_OPCODE = 8'hff;
  localparam int LV_RESET_SEL_BIT = 1;
  localparam logic [7:0] LVCTRL_RESET = 8'h00;
  localparam logic [2:0] RESET_HOLD_CYCLES = 3'h4;
endpackage : ivpr_pkg

// ### ivpr_sync2.sv
// Two-stage synchroniser for one asynchronous level.
// Assumes clk_sys_in is the only clock.
`timescale 1ns/100ps
`default_nettype none
module ivpr_sync2 (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Level in and out.
  input wire logic async_in,
  output logic sync_out
);
  logic meta_reg;
  logic sync_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule : ivpr_sync2
`default_nettype wire

// ### ivpr_pending.sv
// Sticky pending flag for one maskable request; a new event beats the clear.
// Assumes the event and acknowledge come from logic on clk_sys_in.
`timescale 1ns/100ps
`default_nettype none
module ivpr_pending (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Event and acknowledge.
  input wire logic event_in,
  input wire logic ack_in,
  output logic pend_out
);
  logic pend_reg;
  logic pend_next;

  // Set wins over clear when both land together.
  assign pend_next = event_in | (pend_reg & ~ack_in);

  // Holds the request until the core takes it.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pend_reg <= 1'b0;
    end else begin
      pend_reg <= pend_next;
    end
  end

  assign pend_out = pend_reg;
endmodule : ivpr_pending
`default_nettype wire

// ### ivpr_core_model.sv
// Behavioural model of the core side of the interrupt handshake.
// Assumes it shares clk_sys_in and rst_in with the block under test.
`timescale 1ns/100ps
`default_nettype none
module ivpr_core_model (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Request from the block and cycles to wait before taking it.
  input wire logic irq_req_in,
  input wire logic [19:0] irq_vector_in,
  input wire logic [5:0] irq_prio_in,
  input wire logic [3:0] ack_delay_in,
  // Acknowledge and what was taken.
  output logic irq_ack_out,
  output logic taken_out,
  output logic [19:0] taken_vector_out,
  output logic [5:0] taken_prio_out
);
  int idle_cnt;

  // Acknowledge is held until an edge sees the request high, then dropped.
  // A cool-down of three cycles plus ack_delay_in lets the registered request catch up first.
  always @(posedge clk_sys_in) begin
    taken_out <= 1'b0;
    if (rst_in) begin
      irq_ack_out <= 1'b0;
      idle_cnt <= 0;
    end else if (irq_ack_out && irq_req_in) begin
      taken_out <= 1'b1;
      taken_vector_out <= irq_vector_in;
      taken_prio_out <= irq_prio_in;
      irq_ack_out <= 1'b0;
      idle_cnt <= 0;
    end else if (!irq_ack_out) begin
      if (irq_req_in && idle_cnt >= 3 + int'(ack_delay_in)) begin
        irq_ack_out <= 1'b1;
      end
      if (idle_cnt < 100) begin
        idle_cnt <= idle_cnt + 1;
      end
    end
  end
endmodule : ivpr_core_model
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the vector, priority and reset block.
// Assumes the core model is compiled before this file.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic [4:0] ev = '0;
  logic irq_ack, irq_req, exec = 1'b0, sw_break = 1'b0, dbg = 1'b0, break_req;
  logic [19:0] irq_vec, break_vec, pc_vector_out, pcv, tvec;
  logic [5:0] irq_prio, tprio;
  logic [7:0] opc = 8'h00, lvctrl = 8'h00;
  logic pin_n = 1'b1, pwr_clr = 1'b0, lvd = 1'b0, wdog = 1'b0, halt = 1'b0;
  logic hrel, core_reset_out, pc_load_out, taken;
  logic [4:0] reset_cause_out;
  logic [4:0] seen = '0;
  logic [3:0] delay = 4'h0;
  int break_len = 0;
  int fails = 0;
  int check_count = 0;

  // Clock of 8 ns period.
  always #4 clk_sys_in = ~clk_sys_in;

  ivpr_top dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .timer_ch10_done_irq_in(ev[0]), .timer_ch11_done_irq_in(ev[1]),
    .timer_ch12_done_irq_in(ev[2]), .timer_ch13_done_irq_in(ev[3]),
    .muldiv_done_irq_in(ev[4]), .irq_ack_in(irq_ack), .irq_req_out(irq_req),
    .irq_vector_out(irq_vec), .irq_prio_out(irq_prio), .instr_exec_in(exec),
    .instr_opcode_in(opc), .software_break_instr_in(sw_break), .debug_emulation_in(dbg),
    .break_req_out(break_req), .break_vector_out(break_vec), .reset_pin_n_in(pin_n),
    .power_on_clear_in(pwr_clr), .low_voltage_detect_in(lvd), .low_voltage_ctrl_reg_in(lvctrl),
    .watchdog_overflow_reset_in(wdog), .halt_active_in(halt), .halt_release_out(hrel),
    .core_reset_out(core_reset_out), .pc_load_out(pc_load_out),
    .pc_vector_out(pc_vector_out), .reset_cause_out(reset_cause_out));

  ivpr_core_model core (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .irq_req_in(irq_req),
    .irq_vector_in(irq_vec), .irq_prio_in(irq_prio), .ack_delay_in(delay),
    .irq_ack_out(irq_ack), .taken_out(taken), .taken_vector_out(tvec),
    .taken_prio_out(tprio));

  // Sticky records of reset, reset vector load, halt release, break and take outputs, so short pulses are never missed.
  always @(posedge clk_sys_in) begin
    if (core_reset_out === 1'b1) seen[0] <= 1'b1;
    if (pc_load_out === 1'b1) seen[1] <= 1'b1;
    if (pc_load_out === 1'b1) pcv <= pc_vector_out;
    if (hrel === 1'b1) seen[2] <= 1'b1;
    if (break_req === 1'b1) seen[3] <= 1'b1;
    if (break_req === 1'b1) break_len <= break_len + 1;
    if (taken === 1'b1) seen[4] <= 1'b1;
  end

  task tick();
    @(posedge clk_sys_in);
    #1;
  endtask : tick

  task results();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  task check_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
      fails++;
    end
  endtask : check_bit

  task check_vec(input logic [19:0] got, input logic [19:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: value %h expected %h", $time, got, exp);
      fails++;
    end
  endtask : check_vec

  // Waits for a sticky record to be set; running out of cycles ends the run.
  task automatic wait_ev(input int which, input int lim);
    int n;
    n = 0;
    while (seen[which] !== 1'b1 && n < lim) begin
      tick();
      n++;
    end
    if (seen[which] !== 1'b1) begin
      $display("CHECK FAILED at %0t: timeout waiting on event %0d", $time, which);
      fails++;
      results();
    end
  endtask : wait_ev

  // All five maskable sources fire together and must be taken in priority order.
  task t_priority();
    logic [19:0] exp_vec [5];
    logic [5:0] exp_prio [5];
    exp_vec = '{ivpr_pkg::VEC_TM10, ivpr_pkg::VEC_TM11, ivpr_pkg::VEC_TM12,
      ivpr_pkg::VEC_TM13, ivpr_pkg::VEC_MULDIV};
    exp_prio = '{6'h29, 6'h2a, 6'h2b, 6'h2c, 6'h2d};
    delay = 4'h2;
    ev = 5'h1f;
    tick();
    ev = 5'h00;
    for (int i = 0; i < 5; i++) begin
      seen[4] = 1'b0;
      wait_ev(4, 60);
      check_vec(tvec, exp_vec[i]);
      check_vec({14'h0000, tprio}, {14'h0000, exp_prio[i]});
    end
    repeat (6) tick();
    check_bit(irq_req, 1'b0);
    $display("test priority done");
  endtask : t_priority

  // A break is a one-cycle non-maskable request at its own vector.
  task t_break();
    seen = '0;
    break_len = 0;
    exec = 1'b1;
    sw_break = 1'b1;
    tick();
    exec = 1'b0;
    sw_break = 1'b0;
    wait_ev(3, 10);
    repeat (4) tick();
    check_vec(break_vec, ivpr_pkg::VEC_BREAK);
    check_bit(break_len == 1, 1'b1);
    check_bit(irq_req, 1'b0);
    $display("test break done");
  endtask : t_break

  task set_src(input int src, input logic on);
    case (src)
      0: pin_n = !on;
      1: pwr_clr = on;
      2: lvd = on;
      3: wdog = on;
      default: begin
        exec = on;
        opc = on ? ivpr_pkg::ILLEGAL_OPCODE : 8'h00;
      end
    endcase
  endtask : set_src

  // One reset source is raised; a reset must follow only if expected.
  task automatic t_rst(input int src, input logic exp, input string nm);
    seen = '0;
    set_src(src, 1'b1);
    repeat ((src == 4) ? 1 : 4) tick();
    set_src(src, 1'b0);
    repeat (8) tick();
    check_bit(seen[0], exp);
    check_bit(seen[2], exp & halt);
    if (exp) begin
      wait_ev(1, 40);
      check_vec(pcv, ivpr_pkg::VEC_RESET);
      check_bit(reset_cause_out[src], 1'b1);
    end
    repeat (4) tick();
    $display("test %s done", nm);
  endtask : t_rst

  initial begin
    repeat (10) tick();
    rst_in = 1'b0;
    wait_ev(1, 40);
    t_priority();
    t_break();
    t_rst(0, 1'b1, "pin");
    t_rst(1, 1'b1, "power on clear");
    t_rst(2, 1'b0, "low voltage unselected");
    lvctrl = 8'h02;
    t_rst(2, 1'b1, "low voltage selected");
    dbg = 1'b1;
    t_rst(4, 1'b0, "trap under emulation");
    dbg = 1'b0;
    t_rst(4, 1'b1, "trap");
    halt = 1'b1;
    t_rst(3, 1'b1, "watchdog in halt");
    check_bit(seen[2], 1'b1);
    halt = 1'b0;
    results();
  end
endmodule : testbench
`default_nettype wire
